//--- logic/ast_timing.sv
// Conversion timing configuration and settle/interval timer with AXI4-Lite registers.
// Assumes the sequencer on the same clock issues one channel request at a time.

// Operation
// - Cell delay field bits 6:4 picks settle
// - Settle on first cell/aux request only, not for oversamples
// - Aux delay field bits 2:0 picks settle
// - Delay register bits 7,3 read zero
// - Cell interval field bits 7:4 times cells
// - Bits 3:0 time die temperature channel
// - Interval codes decode through shared table
// - Aux channel n nibble from bit 31 down
module ast_timing #(
   parameter ast_pkg::ast_dly_tab_t DLY_CYC = ast_pkg::ast_dly_default(),
   parameter ast_pkg::ast_int_tab_t INT_CYC = ast_pkg::ast_int_default()
) (
   input  wire  logic                      aclk,
   input  wire  logic                      aresetn,
   input  wire  logic [ast_pkg::ADDR_W-1:0] awaddr,
   input  wire  logic                      awvalid,
   output logic                            awready,
   input  wire  logic [31:0]               wdata,
   input  wire  logic [3:0]                wstrb,
   input  wire  logic                      wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire  logic                      bready,
   input  wire  logic [ast_pkg::ADDR_W-1:0] araddr,
   input  wire  logic                      arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire  logic                      rready,
   input  wire  ast_pkg::ast_req_s         req,
   output logic                            req_ready,
   output logic                            sample_strobe,
   output logic                            settling,
   output ast_pkg::ast_cfg_s               cfg
);
   import ast_pkg::*;

   for (genvar i = 0; i < 16; i++) begin : g_chk
      if (INT_CYC[i] < 1 || INT_CYC[i] >= (1 << CW) || (i < 8 && DLY_CYC[i % 8] >= (1 << CW)))
         $error("Timing table entry out of counter range");
   end

   logic [7:0]  dly_r;
   logic [7:0]  cell_r;
   logic [31:0] aux_r;

   logic        aw_got_r;
   logic [7:0]  aw_idx_r;
   logic        w_got_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        wr_go;

   ast_state_e  state_r;
   ast_cnt_t    cnt_r;
   logic [3:0]  int_code_r;
   logic        sample_r;
   logic        accept;
   logic [2:0]  dly_code;
   logic [3:0]  int_code;
   logic        use_settle;

   // Write channel: address and data taken in either order
   assign awready = !aw_got_r && !bvalid_r;
   assign wready  = !w_got_r && !bvalid_r;
   assign wr_go   = aw_got_r && w_got_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         aw_idx_r <= 8'h00;
         w_got_r  <= 1'b0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= awaddr[ADDR_W-1:2];
         end
         if (wvalid && wready) begin
            w_got_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= (aw_idx_r inside {IDX_DELAY, IDX_CELL, IDX_AUX, IDX_STATUS}) ?
                        RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Register storage with byte lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dly_r  <= RST_DELAY;
         cell_r <= RST_CELL;
         aux_r  <= RST_AUX;
      end else if (wr_go) begin
         if (aw_idx_r == IDX_DELAY && wstrb_r[0]) begin
            dly_r <= wdata_r[7:0] & ~DLY_RSVD_MASK;
         end
         if (aw_idx_r == IDX_CELL && wstrb_r[0]) begin
            cell_r <= wdata_r[7:0];
         end
         if (aw_idx_r == IDX_AUX) begin
            for (int b = 0; b < 4; b++) begin
               if (wstrb_r[b]) begin
                  aux_r[8*b +: 8] <= wdata_r[8*b +: 8];
               end
            end
         end
      end
   end

   // Read channel
   assign arready = !rvalid_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         unique case (araddr[ADDR_W-1:2])
            IDX_DELAY:  rdata_r <= {24'h00_0000, dly_r & ~DLY_RSVD_MASK};
            IDX_CELL:   rdata_r <= {24'h00_0000, cell_r};
            IDX_AUX:    rdata_r <= aux_r;
            IDX_STATUS: rdata_r <= {30'h0000_0000, state_r == AST_SAMPLE,
                                    state_r == AST_SETTLE};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign cfg.cell_initial_delay       = dly_r[CELL_DLY_LSB +: 3];
   assign cfg.aux_initial_delay        = dly_r[AUX_DLY_LSB +: 3];
   assign cfg.cell_sample_interval     = cell_r[CELL_INT_LSB +: 4];
   assign cfg.die_temp_sample_interval = cell_r[TEMP_INT_LSB +: 4];
   assign cfg.aux_sample_interval      = aux_r;

   // Channel timer
   assign req_ready     = (state_r == AST_IDLE);
   assign accept        = req.valid && req_ready;
   assign settling      = (state_r == AST_SETTLE);
   assign sample_strobe = sample_r;
   assign dly_code = (req.grp == AST_AUX) ? cfg.aux_initial_delay : cfg.cell_initial_delay;
   assign use_settle = req.first && !req.oversample && req.grp != AST_TEMP &&
                       DLY_CYC[dly_code] != 0;

   always_comb begin
      unique case (req.grp)
         AST_CELL: int_code = cfg.cell_sample_interval;
         AST_TEMP: int_code = cfg.die_temp_sample_interval;
         AST_AUX:  int_code = aux_r[31 - 4*req.aux_ch -: 4];
         default:  int_code = cfg.cell_sample_interval;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= AST_IDLE;
         cnt_r      <= '0;
         int_code_r <= 4'h0;
      end else begin
         unique case (state_r)
            AST_IDLE: if (accept) begin
               int_code_r <= int_code;
               if (use_settle) begin
                  state_r <= AST_SETTLE;
                  cnt_r   <= CW'(DLY_CYC[dly_code]);
               end else begin
                  state_r <= AST_SAMPLE;
                  cnt_r   <= CW'(INT_CYC[int_code]);
               end
            end
            AST_SETTLE: if (cnt_r == 1) begin
               state_r <= AST_SAMPLE;
               cnt_r   <= CW'(INT_CYC[int_code_r]);
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
            AST_SAMPLE: if (cnt_r == 1) begin
               state_r <= AST_IDLE;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_r <= 1'b0;
      end else begin
         sample_r <= (state_r == AST_SAMPLE) && (cnt_r == 1);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_cell_delay;
      accept && req.grp == AST_CELL && use_settle |=>
         state_r == AST_SETTLE && cnt_r == CW'(DLY_CYC[$past(dly_r[6:4])]);
   endproperty
   a_cell_delay: assert property (p_cell_delay) else $error("Cell settle count wrong");

   property p_once;
      accept && req.oversample |=> state_r == AST_SAMPLE;
   endproperty
   a_once: assert property (p_once) else $error("Settle repeated on oversample");

   property p_aux_delay;
      accept && req.grp == AST_AUX && use_settle |=>
         state_r == AST_SETTLE && cnt_r == CW'(DLY_CYC[$past(dly_r[2:0])]);
   endproperty
   a_aux_delay: assert property (p_aux_delay) else $error("Aux settle count wrong");

   property p_rsvd;
      (dly_r & DLY_RSVD_MASK) == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("Reserved delay bits set");

   property p_cell_int;
      accept && req.grp == AST_CELL && !use_settle |=>
         cnt_r == CW'(INT_CYC[$past(cell_r[7:4])]);
   endproperty
   a_cell_int: assert property (p_cell_int) else $error("Cell interval wrong");

   property p_temp_int;
      accept && req.grp == AST_TEMP |=>
         state_r == AST_SAMPLE && cnt_r == CW'(INT_CYC[$past(cell_r[3:0])]);
   endproperty
   a_temp_int: assert property (p_temp_int) else $error("Temperature interval wrong");

   property p_strobe;
      state_r == AST_SAMPLE && cnt_r == 1 |=> sample_r && state_r == AST_IDLE;
   endproperty
   a_strobe: assert property (p_strobe) else $error("Sample strobe mistimed");

   property p_aux_int;
      accept && req.grp == AST_AUX && !use_settle |=>
         cnt_r == CW'(INT_CYC[$past(aux_r[31 - 4*req.aux_ch -: 4])]);
   endproperty
   a_aux_int: assert property (p_aux_int) else $error("Aux interval wrong");

   sequence s_settle_end;
      state_r == AST_SETTLE && cnt_r == 1;
   endsequence
   sequence s_sample_start;
      state_r == AST_SAMPLE && cnt_r == CW'(INT_CYC[int_code_r]) && !sample_r;
   endsequence
   property p_order;
      s_settle_end |=> s_sample_start;
   endproperty
   a_order: assert property (p_order) else $error("Conversion began before settle");

endmodule

//--- pkg/ast_pkg.sv
// Constants, types and default timing tables for the conversion timing block.
// Assumes a 50 MHz aclk; tables are built from times in nanoseconds.
package ast_pkg;

   localparam int unsigned CLK_NS  = 20;
   localparam int          CW      = 16;
   localparam int          ADDR_W  = 10;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DELAY  = 8'h3d;
   localparam logic [7:0] IDX_CELL   = 8'h3e;
   localparam logic [7:0] IDX_AUX    = 8'h3f;
   localparam logic [7:0] IDX_STATUS = 8'h48;

   localparam logic [7:0]  RST_DELAY = 8'h00;
   localparam logic [7:0]  RST_CELL  = 8'h44;
   localparam logic [31:0] RST_AUX   = 32'h4444_4444;

   localparam int         CELL_DLY_LSB  = 4;
   localparam int         AUX_DLY_LSB   = 0;
   localparam logic [7:0] DLY_RSVD_MASK = 8'h88;
   localparam int         CELL_INT_LSB  = 4;
   localparam int         TEMP_INT_LSB  = 0;
   localparam int         AUX_CH_N      = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef int unsigned ast_dly_tab_t [8];
   typedef int unsigned ast_int_tab_t [16];

   localparam ast_dly_tab_t DLY_NS = '{0, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
   localparam ast_int_tab_t INT_NS = '{4130, 5960, 8020, 10000, 12600, 14900, 17400, 19900,
                                       24900, 30000, 40100, 60000, 100000, 200000, 500000,
                                       1000000};

   typedef logic [CW-1:0] ast_cnt_t;

   typedef enum logic [1:0] {AST_CELL, AST_TEMP, AST_AUX} ast_group_e;
   typedef enum logic [1:0] {AST_IDLE, AST_SETTLE, AST_SAMPLE} ast_state_e;

   typedef struct packed {
      logic       valid;
      ast_group_e grp;
      logic [2:0] aux_ch;
      logic       first;
      logic       oversample;
   } ast_req_s;

   typedef struct packed {
      logic [2:0]  cell_initial_delay;
      logic [2:0]  aux_initial_delay;
      logic [3:0]  cell_sample_interval;
      logic [3:0]  die_temp_sample_interval;
      logic [31:0] aux_sample_interval;
   } ast_cfg_s;

   // Least times round up to whole cycles
   function automatic int unsigned ast_cyc(input int unsigned ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   function automatic ast_dly_tab_t ast_dly_default();
      ast_dly_tab_t t;
      for (int i = 0; i < 8; i++) begin
         t[i] = ast_cyc(DLY_NS[i]);
      end
      return t;
   endfunction

   function automatic ast_int_tab_t ast_int_default();
      ast_int_tab_t t;
      for (int i = 0; i < 16; i++) begin
         t[i] = ast_cyc(INT_NS[i]);
      end
      return t;
   endfunction

endpackage

//--- verif/ast_timing_tb.sv
// Self-checking bench for the conversion timing block: AXI4-Lite registers and settle timer.
// Assumes the short count tables below are handed to the design in place of the defaults.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ast_pkg::*;

   localparam ast_dly_tab_t TB_DLY = '{0, 2, 3, 4, 5, 6, 7, 8};
   localparam ast_int_tab_t TB_INT = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};

   logic              aclk    = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr  = '0;
   logic [ADDR_W-1:0] araddr  = '0;
   logic              awvalid = 1'b0;
   logic              wvalid  = 1'b0;
   logic              bready  = 1'b0;
   logic              arvalid = 1'b0;
   logic              rready  = 1'b0;
   logic [31:0]       wdata   = '0;
   logic [3:0]        wstrb   = '0;
   ast_req_s          req     = '0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              req_ready, sample_strobe, settling;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   ast_cfg_s          cfg;
   int                num_errors = 0;
   int                n_checks   = 0;

   always #10 aclk = ~aclk;

   ast_timing #(.DLY_CYC(TB_DLY), .INT_CYC(TB_INT)) i_ast_timing (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .req(req),
      .req_ready(req_ready), .sample_strobe(sample_strobe), .settling(settling), .cfg(cfg)
   );

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Handshakes judged at the falling edge, acted on at the next rising edge
   task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
      logic     ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         r  = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            break;
         end
      end
      chk("bresp", er, r);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic       ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            break;
         end
      end
      chk("rdata", ed, d);
      chk("rresp", er, r);
   endtask

   // One request; counts settle cycles and cycles from accept edge to strobe
   task automatic run_req(input ast_group_e g, input logic [2:0] ch, input logic f,
                          input logic o, input int es, input int et);
      int n;
      int ns;
      ns = 0;
      @(posedge aclk);
      req <= '{valid: 1'b1, grp: g, aux_ch: ch, first: f, oversample: o};
      @(posedge aclk);
      req.valid <= 1'b0;
      for (n = 1; n < 200; n++) begin
         @(negedge aclk);
         if (n == 1) chk("req_ready", 32'h0, req_ready);
         if (settling === 1'b1) ns++;
         if (sample_strobe === 1'b1) break;
      end
      chk("settle_cycles", es, ns);
      chk("strobe_cycles", et, n);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(10'h0f4, 32'h0, RESP_OKAY);
      rd_chk(10'h0f8, 32'h44, RESP_OKAY);
      rd_chk(10'h0fc, 32'h4444_4444, RESP_OKAY);
      rd_chk(10'h120, 32'h0, RESP_OKAY);
      $display("test reset_values done");
      axi_wr(10'h0f4, 32'h0000_00ff, 4'h1, RESP_OKAY);
      rd_chk(10'h0f4, 32'h77, RESP_OKAY);
      chk("cell_initial_delay", 32'h7, cfg.cell_initial_delay);
      chk("aux_initial_delay", 32'h7, cfg.aux_initial_delay);
      axi_wr(10'h0f8, 32'h0000_00a5, 4'h1, RESP_OKAY);
      chk("cell_sample_interval", 32'ha, cfg.cell_sample_interval);
      chk("die_temp_sample_interval", 32'h5, cfg.die_temp_sample_interval);
      axi_wr(10'h100, 32'hffff_ffff, 4'hf, RESP_SLVERR);
      rd_chk(10'h100, 32'h0, RESP_SLVERR);
      axi_wr(10'h120, 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd_chk(10'h120, 32'h0, RESP_OKAY);
      rd_chk(10'h0f8, 32'ha5, RESP_OKAY);
      $display("test register_access done");
      for (int c = 0; c < 8; c++) begin
         axi_wr(10'h0f4, 32'(c * 16 + 7 - c), 4'h1, RESP_OKAY);
         run_req(AST_CELL, 3'h0, 1'b1, 1'b0, TB_DLY[c], TB_DLY[c] + 12);
         run_req(AST_AUX, 3'(c), 1'b1, 1'b0, TB_DLY[7 - c], TB_DLY[7 - c] + 6);
      end
      $display("test initial_delays done");
      axi_wr(10'h0f4, 32'h0000_0077, 4'h1, RESP_OKAY);
      run_req(AST_CELL, 3'h0, 1'b1, 1'b1, 0, 12);
      run_req(AST_CELL, 3'h3, 1'b0, 1'b0, 0, 12);
      run_req(AST_AUX, 3'h2, 1'b1, 1'b1, 0, 6);
      run_req(AST_TEMP, 3'h0, 1'b1, 1'b0, 0, 7);
      // Status seen mid-settle, then mid-interval
      @(posedge aclk);
      req <= '{valid: 1'b1, grp: AST_CELL, aux_ch: 3'h0, first: 1'b1, oversample: 1'b0};
      @(posedge aclk);
      req.valid <= 1'b0;
      rd_chk(10'h120, 32'h1, RESP_OKAY);
      repeat (5) @(posedge aclk);
      rd_chk(10'h120, 32'h2, RESP_OKAY);
      wait (req_ready === 1'b1);
      $display("test settle_once done");
      for (int p = 0; p < 2; p++) begin
         axi_wr(10'h0fc, p ? 32'h89ab_cdef : 32'h0123_4567, 4'hf, RESP_OKAY);
         rd_chk(10'h0fc, p ? 32'h89ab_cdef : 32'h0123_4567, RESP_OKAY);
         for (int ch = 0; ch < AUX_CH_N; ch++) begin
            run_req(AST_AUX, 3'(ch), 1'b0, 1'b0, 0, 8 * p + ch + 2);
         end
      end
      chk("aux_sample_interval", 32'h89ab_cdef, cfg.aux_sample_interval);
      axi_wr(10'h0fc, 32'h1122_3344, 4'h5, RESP_OKAY);
      rd_chk(10'h0fc, 32'h8922_cd44, RESP_OKAY);
      $display("test aux_intervals done");
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      stop_test();
   end
endmodule
